// ---- verilog/dma_regs_pkg.sv ----
/*
 * Constants for the two-channel block mover register set: byte offsets, field
 * positions, command codes and reset values.
 * Assumes an 8-bit register port whose offsets are the CPU mode 0/1 addresses.
 */
package dma_regs_pkg;
    // Channel 2 byte offsets.
    localparam logic [7:0] OFS_CH2_TGT_L = 8'hc0;
    localparam logic [7:0] OFS_CH2_TGT_M = 8'hc1;
    localparam logic [7:0] OFS_CH2_TGT_H = 8'hc2;
    localparam logic [7:0] OFS_CH2_CPB = 8'hc6;
    localparam logic [7:0] OFS_CH2_CUR_L = 8'hc8;
    localparam logic [7:0] OFS_CH2_CUR_H = 8'hc9;
    localparam logic [7:0] OFS_CH2_ERR_L = 8'hca;
    localparam logic [7:0] OFS_CH2_ERR_H = 8'hcb;
    localparam logic [7:0] OFS_CH2_BFL_L = 8'hcc;
    localparam logic [7:0] OFS_CH2_BFL_H = 8'hcd;
    localparam logic [7:0] OFS_CH2_CMD = 8'hd5;
    // Channel 3 byte offsets.
    localparam logic [7:0] OFS_CH3_BUF_L = 8'he0;
    localparam logic [7:0] OFS_CH3_BUF_M = 8'he1;
    localparam logic [7:0] OFS_CH3_BUF_H = 8'he2;
    localparam logic [7:0] OFS_CH3_SRC_L = 8'he4;
    localparam logic [7:0] OFS_CH3_SRC_M = 8'he5;
    localparam logic [7:0] OFS_CH3_SRC_H = 8'he6;
    localparam logic [7:0] OFS_CH3_CUR_L = 8'he8;
    localparam logic [7:0] OFS_CH3_CUR_H = 8'he9;
    localparam logic [7:0] OFS_CH3_ERR_L = 8'hea;
    localparam logic [7:0] OFS_CH3_ERR_H = 8'heb;
    localparam logic [7:0] OFS_CH3_LEN_L = 8'hee;
    localparam logic [7:0] OFS_CH3_LEN_H = 8'hef;
    localparam logic [7:0] OFS_CH3_STAT = 8'hf0;
    localparam logic [7:0] OFS_CH3_MODE = 8'hf1;
    localparam logic [7:0] OFS_CH3_FCNT = 8'hf3;
    localparam logic [7:0] OFS_CH3_IRQEN = 8'hf4;
    localparam logic [7:0] OFS_CH3_CMD = 8'hf5;
    // Status and interrupt enable fields; event flags sit in bits 7..4.
    localparam int BIT_TRANSFER_END = 7;
    localparam int BIT_FRAME_END = 6;
    localparam int BIT_BUFFER_OVERRUN = 5;
    localparam int BIT_COUNTER_OVERFLOW = 4;
    localparam int BIT_RUN_ENABLE = 1;
    localparam int BIT_WRITE_GUARD = 0;
    localparam int EVT_LSB = 4;
    // Event vector positions inside the 4-bit flag group.
    localparam int EV_COF = 0;
    localparam int EV_BOF = 1;
    localparam int EV_EOM = 2;
    localparam int EV_EOT = 3;
    // Mode register fields.
    localparam int BIT_CHAIN_SELECT = 4;
    localparam int BIT_MULTI_FRAME = 2;
    localparam int BIT_FRAME_CNT_EN = 1;
    // Command codes in bits 1..0.
    localparam logic [1:0] CMD_ABORT = 2'h1;
    localparam logic [1:0] CMD_CLR_COUNT = 2'h2;
    // Reset values.
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [3:0] RST_NIBBLE = 4'h0;
endpackage : dma_regs_pkg

// ---- verilog/dma_event_if.sv ----
/*
 * Carrier between the register file and the channel 3 event unit.
 * Assumes both ends run on the same system clock.
 */
`timescale 1ns/1ps
interface dma_event_if;
    logic [3:0] events;
    logic [3:0] flag_clear;
    logic count_clear;
    logic chain_mode;
    logic count_enable;
    logic [3:0] irq_enable;
    logic [3:0] flags;
    logic [3:0] frame_count;
    logic irq;

    modport regs (output flag_clear, count_clear, chain_mode, count_enable,
                  output irq_enable, output events, input flags, frame_count, irq);
    modport unit (input flag_clear, count_clear, chain_mode, count_enable,
                  input irq_enable, input events, output flags, frame_count, irq);
endinterface : dma_event_if

// ---- verilog/dma_event_unit.sv ----
/*
 * Sticky event flags, frame end counter and interrupt for channel 3.
 * Assumes events are one-cycle pulses from logic on the same clock.
 */
`timescale 1ns/1ps
module dma_event_unit (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register file side.
    dma_event_if.unit ev
);
    logic [3:0] set_now;
    logic frame_tick;
    logic wrap;

    // Buffer and frame events only count in chained mode.
    assign frame_tick = ev.events[dma_regs_pkg::EV_EOM] & ev.chain_mode;
    assign wrap = frame_tick & ev.count_enable & (ev.frame_count == 4'hf);
    always_comb
    begin
        set_now = ev.events;
        set_now[dma_regs_pkg::EV_BOF] = ev.events[dma_regs_pkg::EV_BOF] & ev.chain_mode;
        set_now[dma_regs_pkg::EV_EOM] = frame_tick;
        set_now[dma_regs_pkg::EV_COF] = ev.events[dma_regs_pkg::EV_COF] | wrap;
    end

    // A set in the same cycle as a write-one clear wins, so no event is lost.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            ev.flags <= dma_regs_pkg::RST_NIBBLE;
        else
            ev.flags <= (ev.flags & ~ev.flag_clear) | set_now;
    end

    // Counter clear and a counted frame (count enable set) in the same cycle leave a count of one.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            ev.frame_count <= dma_regs_pkg::RST_NIBBLE;
        else if (ev.count_clear)
            ev.frame_count <= {3'h0, frame_tick & ev.count_enable};
        else if (frame_tick && ev.count_enable)
            ev.frame_count <= ev.frame_count + 4'h1;
    end

    // Interrupt is registered; overrun enable is ignored in single mode.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            ev.irq <= 1'b0;
        else
            ev.irq <= |(ev.flags & {ev.irq_enable[3:2],
                                    ev.irq_enable[1] & ev.chain_mode,
                                    ev.irq_enable[0]});
    end
endmodule : dma_event_unit

// ---- verilog/dma_channel_regs.sv ----
/*
 * Host register file for block mover channels 2 and 3, with mode-qualified
 * copies of every pointer for the transfer engine.
 * Assumes a single-cycle 8-bit register port on the system clock, the CPU
 * mode held steady by the system controller, and engine events that are
 * one-cycle pulses on the same clock.
 */
`timescale 1ns/1ps
module dma_channel_regs (
    // Clock and reset.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    // Register port.
    input wire logic [1:0] i_cpu_mode,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rd_data,
    // Channel 2 engine side.
    input wire logic i_ch2_chain_mode,
    output logic [23:0] o_ch2_target_address,
    output logic [23:0] o_ch2_buffer_address,
    output logic [7:0] o_ch2_chain_pointer_base,
    output logic [15:0] o_ch2_current_descriptor_pointer,
    output logic [15:0] o_ch2_error_descriptor_pointer,
    output logic [15:0] o_ch2_rx_buffer_length,
    output logic o_ch2_abort,
    // Channel 3 engine side.
    input wire logic i_ch3_transfer_end,
    input wire logic i_ch3_frame_end,
    input wire logic i_ch3_buffer_error,
    input wire logic i_ch3_counter_overflow,
    output logic [23:0] o_ch3_buffer_address,
    output logic [23:0] o_ch3_source_pointer,
    output logic [7:0] o_ch3_chain_pointer_base,
    output logic [15:0] o_ch3_current_descriptor_pointer,
    output logic [15:0] o_ch3_error_descriptor_pointer,
    output logic [15:0] o_ch3_transfer_length,
    output logic o_ch3_chain_select,
    output logic o_ch3_multi_frame_select,
    output logic o_ch3_frame_counter_enable,
    output logic o_ch3_channel_run_enable,
    output logic o_ch3_abort,
    // Interrupt.
    output logic o_irq
);
    logic [7:0] eff_addr;
    logic [7:0] rd_next;
    logic [23:0] ch2_addr_reg;
    logic [7:0] ch2_cpb_reg;
    logic [15:0] ch2_cur_reg;
    logic [15:0] ch2_err_reg;
    logic [15:0] ch2_bfl_reg;
    logic [23:0] ch3_buf_reg;
    logic [23:0] ch3_src_reg;
    logic [15:0] ch3_cur_reg;
    logic [15:0] ch3_err_reg;
    logic [15:0] ch3_len_reg;
    logic [2:0] mode_reg;
    logic [3:0] irqen_reg;
    logic run_reg;
    logic ch3_chain;
    logic ch3_cmd_wr;
    logic [7:0] status_view;
    logic [7:0] mode_view;

    dma_event_if ev ();

    // Modes 2 and 3 put each even/odd byte pair on the other address.
    assign eff_addr = i_cpu_mode[1] ? {i_addr[7:1], ~i_addr[0]} : i_addr;

    // Local write-hit helper keeps the decode readable.
    function automatic logic hit(input logic [7:0] ofs);
        hit = i_wr && (eff_addr == ofs);
    endfunction : hit

    assign ch3_chain = mode_reg[2];
    assign ch3_cmd_wr = hit(dma_regs_pkg::OFS_CH3_CMD);

    // Channel 2 pointer bytes.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            ch2_addr_reg <= {3{dma_regs_pkg::RST_BYTE}};
            ch2_cpb_reg <= dma_regs_pkg::RST_BYTE;
            ch2_cur_reg <= {2{dma_regs_pkg::RST_BYTE}};
            ch2_err_reg <= {2{dma_regs_pkg::RST_BYTE}};
            ch2_bfl_reg <= {2{dma_regs_pkg::RST_BYTE}};
        end
        else
        begin
            if (hit(dma_regs_pkg::OFS_CH2_TGT_L))
                ch2_addr_reg[7:0] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH2_TGT_M))
                ch2_addr_reg[15:8] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH2_TGT_H))
                ch2_addr_reg[23:16] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH2_CPB))
                ch2_cpb_reg <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH2_CUR_L))
                ch2_cur_reg[7:0] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH2_CUR_H))
                ch2_cur_reg[15:8] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH2_ERR_L))
                ch2_err_reg[7:0] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH2_ERR_H))
                ch2_err_reg[15:8] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH2_BFL_L))
                ch2_bfl_reg[7:0] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH2_BFL_H))
                ch2_bfl_reg[15:8] <= i_wr_data;
        end
    end

    // Channel 3 pointer bytes.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            ch3_buf_reg <= {3{dma_regs_pkg::RST_BYTE}};
            ch3_src_reg <= {3{dma_regs_pkg::RST_BYTE}};
            ch3_cur_reg <= {2{dma_regs_pkg::RST_BYTE}};
            ch3_err_reg <= {2{dma_regs_pkg::RST_BYTE}};
            ch3_len_reg <= {2{dma_regs_pkg::RST_BYTE}};
        end
        else
        begin
            if (hit(dma_regs_pkg::OFS_CH3_BUF_L))
                ch3_buf_reg[7:0] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_BUF_M))
                ch3_buf_reg[15:8] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_BUF_H))
                ch3_buf_reg[23:16] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_SRC_L))
                ch3_src_reg[7:0] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_SRC_M))
                ch3_src_reg[15:8] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_SRC_H))
                ch3_src_reg[23:16] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_CUR_L))
                ch3_cur_reg[7:0] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_CUR_H))
                ch3_cur_reg[15:8] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_ERR_L))
                ch3_err_reg[7:0] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_ERR_H))
                ch3_err_reg[15:8] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_LEN_L))
                ch3_len_reg[7:0] <= i_wr_data;
            if (hit(dma_regs_pkg::OFS_CH3_LEN_H))
                ch3_len_reg[15:8] <= i_wr_data;
        end
    end

    // Mode and interrupt enable; mode_reg holds chain, multi-frame, count enable.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode_reg <= 3'h0;
            irqen_reg <= dma_regs_pkg::RST_NIBBLE;
        end
        else
        begin
            if (hit(dma_regs_pkg::OFS_CH3_MODE))
                mode_reg <= {i_wr_data[dma_regs_pkg::BIT_CHAIN_SELECT],
                             i_wr_data[dma_regs_pkg::BIT_MULTI_FRAME],
                             i_wr_data[dma_regs_pkg::BIT_FRAME_CNT_EN]};
            if (hit(dma_regs_pkg::OFS_CH3_IRQEN))
                irqen_reg <= i_wr_data[7:dma_regs_pkg::EVT_LSB];
        end
    end

    // Apart from an abort, run enable moves only on a status write with the guard bit at zero.
    // An abort command also stops the channel so it cannot restart silently.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            run_reg <= 1'b0;
        else if (ch3_cmd_wr && i_wr_data[1:0] == dma_regs_pkg::CMD_ABORT)
            run_reg <= 1'b0;
        else if (hit(dma_regs_pkg::OFS_CH3_STAT) && !i_wr_data[dma_regs_pkg::BIT_WRITE_GUARD])
            run_reg <= i_wr_data[dma_regs_pkg::BIT_RUN_ENABLE];
    end

    // Event unit link: write-one clears, counter clear command, mode bits.
    assign ev.events = {i_ch3_transfer_end, i_ch3_frame_end,
                        i_ch3_buffer_error, i_ch3_counter_overflow};
    assign ev.flag_clear = hit(dma_regs_pkg::OFS_CH3_STAT) ?
                           i_wr_data[7:dma_regs_pkg::EVT_LSB] : 4'h0;
    assign ev.count_clear = ch3_cmd_wr
                            && (i_wr_data[1:0] == dma_regs_pkg::CMD_CLR_COUNT);
    assign ev.chain_mode = ch3_chain;
    assign ev.count_enable = mode_reg[0];
    assign ev.irq_enable = irqen_reg;

    dma_event_unit u_event (
        .i_clk_sys(i_clk_sys),
        .i_rst(i_rst),
        .ev(ev)
    );

    // Status reads flags and run enable; the guard bit always reads zero.
    assign status_view = {ev.flags, 2'h0, run_reg, 1'b0};
    assign mode_view = {3'h0, mode_reg[2], 1'b0, mode_reg[1], mode_reg[0], 1'b0};

    // Read mux; command registers and unmapped offsets read as zero.
    always_comb
    begin
        rd_next = 8'h00;
        case (eff_addr)
            dma_regs_pkg::OFS_CH2_TGT_L: rd_next = ch2_addr_reg[7:0];
            dma_regs_pkg::OFS_CH2_TGT_M: rd_next = ch2_addr_reg[15:8];
            dma_regs_pkg::OFS_CH2_TGT_H: rd_next = ch2_addr_reg[23:16];
            dma_regs_pkg::OFS_CH2_CPB: rd_next = ch2_cpb_reg;
            dma_regs_pkg::OFS_CH2_CUR_L: rd_next = ch2_cur_reg[7:0];
            dma_regs_pkg::OFS_CH2_CUR_H: rd_next = ch2_cur_reg[15:8];
            dma_regs_pkg::OFS_CH2_ERR_L: rd_next = ch2_err_reg[7:0];
            dma_regs_pkg::OFS_CH2_ERR_H: rd_next = ch2_err_reg[15:8];
            dma_regs_pkg::OFS_CH2_BFL_L: rd_next = ch2_bfl_reg[7:0];
            dma_regs_pkg::OFS_CH2_BFL_H: rd_next = ch2_bfl_reg[15:8];
            dma_regs_pkg::OFS_CH3_BUF_L: rd_next = ch3_buf_reg[7:0];
            dma_regs_pkg::OFS_CH3_BUF_M: rd_next = ch3_buf_reg[15:8];
            dma_regs_pkg::OFS_CH3_BUF_H: rd_next = ch3_buf_reg[23:16];
            dma_regs_pkg::OFS_CH3_SRC_L: rd_next = ch3_src_reg[7:0];
            dma_regs_pkg::OFS_CH3_SRC_M: rd_next = ch3_src_reg[15:8];
            dma_regs_pkg::OFS_CH3_SRC_H: rd_next = ch3_src_reg[23:16];
            dma_regs_pkg::OFS_CH3_CUR_L: rd_next = ch3_cur_reg[7:0];
            dma_regs_pkg::OFS_CH3_CUR_H: rd_next = ch3_cur_reg[15:8];
            dma_regs_pkg::OFS_CH3_ERR_L: rd_next = ch3_err_reg[7:0];
            dma_regs_pkg::OFS_CH3_ERR_H: rd_next = ch3_err_reg[15:8];
            dma_regs_pkg::OFS_CH3_LEN_L: rd_next = ch3_len_reg[7:0];
            dma_regs_pkg::OFS_CH3_LEN_H: rd_next = ch3_len_reg[15:8];
            dma_regs_pkg::OFS_CH3_STAT: rd_next = status_view;
            dma_regs_pkg::OFS_CH3_MODE: rd_next = mode_view;
            dma_regs_pkg::OFS_CH3_FCNT: rd_next = {4'h0, ev.frame_count};
            dma_regs_pkg::OFS_CH3_IRQEN: rd_next = {irqen_reg, 4'h0};
            default: rd_next = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            o_rd_data <= dma_regs_pkg::RST_BYTE;
        else
            o_rd_data <= i_rd ? rd_next : 8'h00;
    end

    // Channel 2 engine view, qualified by its transfer mode.
    // The one-cycle lag is harmless: pointers are set before a channel runs.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_ch2_target_address <= 24'h000000;
            o_ch2_buffer_address <= 24'h000000;
            o_ch2_chain_pointer_base <= dma_regs_pkg::RST_BYTE;
            o_ch2_current_descriptor_pointer <= 16'h0000;
            o_ch2_error_descriptor_pointer <= 16'h0000;
            o_ch2_rx_buffer_length <= 16'h0000;
        end
        else
        begin
            o_ch2_target_address <= i_ch2_chain_mode ? 24'h000000 : ch2_addr_reg;
            o_ch2_buffer_address <= i_ch2_chain_mode ? ch2_addr_reg : 24'h000000;
            o_ch2_chain_pointer_base <= i_ch2_chain_mode ? ch2_cpb_reg : 8'h00;
            o_ch2_current_descriptor_pointer <= i_ch2_chain_mode ? ch2_cur_reg : 16'h0000;
            o_ch2_error_descriptor_pointer <= i_ch2_chain_mode ? ch2_err_reg : 16'h0000;
            o_ch2_rx_buffer_length <= i_ch2_chain_mode ? ch2_bfl_reg : 16'h0000;
        end
    end

    // Channel 3 engine view, qualified by the chain select bit.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_ch3_buffer_address <= 24'h000000;
            o_ch3_source_pointer <= 24'h000000;
            o_ch3_chain_pointer_base <= dma_regs_pkg::RST_BYTE;
            o_ch3_current_descriptor_pointer <= 16'h0000;
            o_ch3_error_descriptor_pointer <= 16'h0000;
            o_ch3_transfer_length <= 16'h0000;
        end
        else
        begin
            o_ch3_buffer_address <= ch3_chain ? ch3_buf_reg : 24'h000000;
            o_ch3_source_pointer <= ch3_chain ? 24'h000000 : ch3_src_reg;
            o_ch3_chain_pointer_base <= ch3_chain ? ch3_src_reg[23:16] : 8'h00;
            o_ch3_current_descriptor_pointer <= ch3_chain ? ch3_cur_reg : 16'h0000;
            o_ch3_error_descriptor_pointer <= ch3_chain ? ch3_err_reg : 16'h0000;
            o_ch3_transfer_length <= ch3_chain ? 16'h0000 : ch3_len_reg;
        end
    end

    // Control outputs and abort pulses.
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_ch3_chain_select <= 1'b0;
            o_ch3_multi_frame_select <= 1'b0;
            o_ch3_frame_counter_enable <= 1'b0;
            o_ch3_channel_run_enable <= 1'b0;
            o_ch2_abort <= 1'b0;
            o_ch3_abort <= 1'b0;
        end
        else
        begin
            o_ch3_chain_select <= ch3_chain;
            o_ch3_multi_frame_select <= mode_reg[1];
            o_ch3_frame_counter_enable <= mode_reg[0];
            o_ch3_channel_run_enable <= run_reg;
            o_ch2_abort <= hit(dma_regs_pkg::OFS_CH2_CMD)
                           && (i_wr_data[1:0] == dma_regs_pkg::CMD_ABORT);
            o_ch3_abort <= ch3_cmd_wr && (i_wr_data[1:0] == dma_regs_pkg::CMD_ABORT);
        end
    end

    // The event unit already registers the interrupt level.
    assign o_irq = ev.irq;
endmodule : dma_channel_regs

// ---- bench/dma_regs_assertions.sv ----
/* Port checker for the channel register block; bound to its top module. */
`timescale 1ns/1ps
module dma_regs_chk (
    // Clock, reset and register port.
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic [1:0] i_cpu_mode,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rd_data,
    // Engine side.
    input wire logic i_ch3_transfer_end,
    input wire logic i_ch3_frame_end,
    input wire logic i_ch3_buffer_error,
    input wire logic i_ch3_counter_overflow,
    input wire logic [23:0] o_ch2_target_address,
    input wire logic [23:0] o_ch2_buffer_address,
    input wire logic [23:0] o_ch3_source_pointer,
    input wire logic [15:0] o_ch3_transfer_length,
    input wire logic [15:0] o_ch3_current_descriptor_pointer,
    input wire logic o_ch3_chain_select,
    input wire logic o_ch3_channel_run_enable,
    input wire logic o_ch3_abort,
    input wire logic o_irq
);
    // Event group for the interrupt-cause check, and plain-mode decode shared by several properties.
    logic [3:0] evt;
    logic lo;
    assign evt = {i_ch3_transfer_end, i_ch3_frame_end, i_ch3_buffer_error, i_ch3_counter_overflow};
    assign lo = !i_cpu_mode[1];
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    AST_CH2_SPLIT: assert property (o_ch2_target_address != 24'h0
        |-> o_ch2_buffer_address == 24'h0) else $error("ch2 address on both outputs");
    AST_CH3_SINGLE: assert property (o_ch3_chain_select
        |-> o_ch3_source_pointer == 24'h0 && o_ch3_transfer_length == 16'h0)
        else $error("single-mode outputs live while chained");
    AST_CH3_DESC: assert property (!o_ch3_chain_select
        |-> o_ch3_current_descriptor_pointer == 16'h0) else $error("descriptor live in single");
    AST_FCNT_UPPER: assert property (i_rd && lo && i_addr == 8'hf3
        |=> o_rd_data[7:4] == 4'h0) else $error("counter upper bits set");
    AST_CMD_READ: assert property (i_rd && lo && i_addr == 8'hf5
        |=> o_rd_data == 8'h00) else $error("command register readable");
    AST_MODE_UNUSED: assert property (i_rd && lo && i_addr == 8'hf1
        |=> (o_rd_data & 8'he9) == 8'h00) else $error("unused mode bits set");
    AST_ABORT: assert property (i_wr && lo && i_addr == 8'hf5 && i_wr_data[1:0] == 2'h1
        |=> ##[0:1] o_ch3_abort) else $error("abort pulse missing");
    AST_IRQ_CAUSE: assert property ($rose(o_irq)
        |-> $past(i_wr, 2) || $past(evt, 2) != 4'h0) else $error("interrupt without cause");
    AST_RUN_GUARD: assert property ($changed(o_ch3_channel_run_enable)
        |-> $past(i_wr) || $past(i_wr, 2)) else $error("run enable changed without write");
endmodule : dma_regs_chk
bind dma_channel_regs dma_regs_chk u_chk (.*);

// ---- bench/engine_model.sv ----
/* Transfer engine stand-in; assumes the bench requests events on the system clock. */
`timescale 1ns/1ps
module engine_model (
    // Clock and request.
    input wire logic i_clk_sys,
    input wire logic [3:0] i_fire,
    // Pulses: transfer end, frame end, buffer error, counter overflow.
    output logic [3:0] o_ev
);
    // Registered so that every event is a clean one-cycle pulse.
    always_ff @(posedge i_clk_sys)
    begin
        o_ev <= i_fire;
    end
endmodule : engine_model

// ---- bench/tb.sv ----
/* Register-level test of the channel register block; assumes the engine model. */
`timescale 1ns/1ps
module tb;
    logic i_clk_sys, i_rst, i_wr, i_rd, i_ch2_chain_mode, o_ch2_abort, o_ch3_abort, o_irq;
    logic i_ch3_transfer_end, i_ch3_frame_end, i_ch3_buffer_error, i_ch3_counter_overflow;
    logic o_ch3_chain_select, o_ch3_multi_frame_select, o_ch3_frame_counter_enable;
    logic o_ch3_channel_run_enable;
    logic [1:0] i_cpu_mode;
    logic [3:0] fire;
    logic [7:0] i_addr, i_wr_data, o_rd_data, o_ch2_chain_pointer_base, o_ch3_chain_pointer_base;
    logic [15:0] o_ch2_current_descriptor_pointer, o_ch2_error_descriptor_pointer;
    logic [15:0] o_ch2_rx_buffer_length, o_ch3_current_descriptor_pointer;
    logic [15:0] o_ch3_error_descriptor_pointer, o_ch3_transfer_length;
    logic [23:0] o_ch2_target_address, o_ch2_buffer_address, o_ch3_buffer_address;
    logic [23:0] o_ch3_source_pointer;
    logic [7:0] rst_ofs [3] = '{8'hf1, 8'hf3, 8'hf4};
    int mismatches, n_checks, cyc;
    dma_channel_regs uut (.*);
    engine_model em (.i_clk_sys(i_clk_sys), .i_fire(fire), .o_ev({i_ch3_transfer_end,
        i_ch3_frame_end, i_ch3_buffer_error, i_ch3_counter_overflow}));
    // Free-running system clock.
    initial
    begin
        i_clk_sys = 1'b0;
        forever #2 i_clk_sys = ~i_clk_sys;
    end
    task automatic chk(input logic [23:0] g, input logic [23:0] e);
        n_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge i_clk_sys);
        #1;
    endtask : wt
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk_sys);
        i_wr <= 1'b0;
    endtask : wr
    // Read data is looked at only in the single cycle after the strobe.
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk_sys);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk_sys);
        i_rd <= 1'b0;
        #1;
        chk({16'h0, o_rd_data}, {16'h0, e});
    endtask : rd
    task automatic ev(input logic [3:0] m);
        @(posedge i_clk_sys);
        fire <= m;
        @(posedge i_clk_sys);
        fire <= 4'h0;
        wt(3);
    endtask : ev
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : conclude
    // A hang ends the run well beyond the few hundred cycles the tests need.
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            mismatches++;
            conclude();
        end
    end
    initial
    begin
        {i_rst, i_wr, i_rd, i_addr, i_wr_data, i_cpu_mode, i_ch2_chain_mode} = 22'h200000;
        {fire, mismatches, n_checks, cyc} = '0;
        repeat (6) @(posedge i_clk_sys);
        i_rst <= 1'b0;
        foreach (rst_ofs[k]) rd(rst_ofs[k], 8'h00);
        wr(8'hc0, 8'h5a);
        wr(8'hc2, 8'ha5);
        i_cpu_mode <= 2'h2;
        rd(8'hc1, 8'h5a);
        wr(8'hc0, 8'h3c);
        i_cpu_mode <= 2'h0;
        rd(8'hc1, 8'h3c);
        chk(o_ch2_target_address, 24'ha53c5a);
        i_ch2_chain_mode <= 1'b1;
        wt(3);
        chk(o_ch2_buffer_address, 24'ha53c5a);
        wr(8'he4, 8'h77);
        wr(8'he6, 8'h99);
        wt(2);
        chk(o_ch3_source_pointer, 24'h990077);
        wr(8'hf1, 8'hff);
        rd(8'hf1, 8'h16);
        chk(o_ch3_source_pointer, 24'h0);
        chk({16'h0, o_ch3_chain_pointer_base}, 24'h99);
        chk({22'h0, o_ch3_multi_frame_select, o_ch3_frame_counter_enable}, 24'h3);
        wr(8'hc6, 8'h11);
        wr(8'hcb, 8'h33);
        wr(8'hcd, 8'h44);
        wr(8'he8, 8'h55);
        wr(8'hee, 8'h66);
        wt(2);
        chk({16'h0, o_ch2_chain_pointer_base}, 24'h11);
        chk({8'h0, o_ch2_error_descriptor_pointer}, 24'h3300);
        chk({8'h0, o_ch2_rx_buffer_length}, 24'h4400);
        chk({8'h0, o_ch3_current_descriptor_pointer}, 24'h55);
        chk({8'h0, o_ch3_transfer_length}, 24'h0);
        wr(8'hc3, 8'hff);
        rd(8'hc3, 8'h00);
        wr(8'hf3, 8'hff);
        rd(8'hf3, 8'h00);
        rd(8'hf5, 8'h00);
        wr(8'hf4, 8'h80);
        ev(4'h8);
        chk({23'h0, o_irq}, 24'h1);
        rd(8'hf0, 8'h80);
        wr(8'hf0, 8'h80);
        wt(2);
        chk({23'h0, o_irq}, 24'h0);
        wr(8'hf4, 8'h00);
        ev(4'h8);
        chk({23'h0, o_irq}, 24'h0);
        wr(8'hf0, 8'hf0);
        repeat (3) ev(4'h4);
        rd(8'hf3, 8'h03);
        wr(8'hf5, 8'h02);
        rd(8'hf3, 8'h00);
        repeat (16) ev(4'h4);
        rd(8'hf0, 8'h50);
        wr(8'hf0, 8'hf0);
        wr(8'hf4, 8'h20);
        ev(4'h2);
        chk({23'h0, o_irq}, 24'h1);
        rd(8'hf0, 8'h20);
        wr(8'hf1, 8'h00);
        wt(2);
        chk({23'h0, o_irq}, 24'h0);
        chk({8'h0, o_ch3_transfer_length}, 24'h66);
        chk({8'h0, o_ch3_current_descriptor_pointer}, 24'h0);
        wr(8'hf0, 8'hf0);
        ev(4'h2);
        rd(8'hf0, 8'h00);
        wr(8'hf0, 8'h03);
        wt(2);
        chk({23'h0, o_ch3_channel_run_enable}, 24'h0);
        wr(8'hf0, 8'h02);
        wt(2);
        chk({23'h0, o_ch3_channel_run_enable}, 24'h1);
        i_ch2_chain_mode <= 1'b0;
        wr(8'hd5, 8'h01);
        #1;
        chk({23'h0, o_ch2_abort}, 24'h1);
        chk({16'h0, o_ch2_chain_pointer_base}, 24'h0);
        wr(8'hf5, 8'h01);
        #1;
        chk({23'h0, o_ch3_abort}, 24'h1);
        wt(2);
        chk({23'h0, o_ch3_channel_run_enable}, 24'h0);
        conclude();
    end
endmodule : tb
